// [shared/qcr_pkg.sv]
// constants and companding function shared by the channel routing block
package qcr_pkg;
	localparam int unsigned NCH   = 4;
	localparam int unsigned DW    = 8;
	localparam int unsigned AW    = 8;
	localparam int unsigned SLOTW = 7;
	localparam int unsigned BITW  = 10;
	localparam int unsigned CSW   = 3;
	localparam int unsigned NHWY  = 2;
	localparam int unsigned NGCI  = 2;

	localparam logic [7:0] A_RESET  = 8'h02;
	localparam logic [7:0] A_TXS_W  = 8'h40;
	localparam logic [7:0] A_TXS_R  = 8'h41;
	localparam logic [7:0] A_RXS_W  = 8'h42;
	localparam logic [7:0] A_RXS_R  = 8'h43;
	localparam logic [7:0] A_CLK_W  = 8'h44;
	localparam logic [7:0] A_CLK_R  = 8'h45;
	localparam logic [7:0] A_CFG_W  = 8'h46;
	localparam logic [7:0] A_CFG_R  = 8'h47;
	localparam logic [7:0] A_CSEL_W = 8'h4a;
	localparam logic [7:0] A_CSEL_R = 8'h4b;
	localparam logic [7:0] A_STAT_R = 8'h4d;
	localparam logic [7:0] A_MODE_W = 8'h60;
	localparam logic [7:0] A_MODE_R = 8'h61;
	localparam logic [7:0] A_SIG_W  = 8'h62;
	localparam logic [7:0] A_SIG_R  = 8'h63;
	localparam logic [7:0] A_MON_W  = 8'h70;
	localparam logic [7:0] A_MON_R  = 8'h71;
	localparam logic [7:0] A_SC_W   = 8'h72;
	localparam logic [7:0] A_SC_R   = 8'h73;
	localparam logic [7:0] A_MONRX  = 8'h74;
	localparam logic [7:0] A_SCRX   = 8'h75;

	localparam int unsigned HWY_BIT  = 7;
	localparam int unsigned EDGE_BIT = 3;
	localparam int unsigned MCLK_BIT = 0;
	localparam int unsigned M_ALAW   = 0;
	localparam int unsigned M_LIN    = 1;
	localparam int unsigned M_SIG    = 2;

	localparam logic [7:0] RST_SLOT = 8'h00;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [7:0] RST_MON  = 8'hff;
	localparam logic [7:0] RST_SC   = 8'hff;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	localparam logic [1:0] GCI_MON_OFS = 2'h2;
	localparam logic [1:0] GCI_SC_OFS  = 2'h3;

	localparam int unsigned LINK_MIN_HZ = 128000;
	localparam int unsigned LINK_MAX_HZ = 8192000;

	// sign-magnitude segment coding of a 16-bit two's complement sample
	function automatic logic [7:0] compand(input logic [15:0] s,
		input logic alaw);
		logic        sg;
		logic [14:0] mag;
		logic [12:0] m;
		logic [2:0]  e;
		logic [3:0]  sh;
		logic [3:0]  mt;
		sg  = s[15];
		mag = sg ? ~s[14:0] : s[14:0];
		if (alaw)
			m = {1'b0, mag[14:3]};
		else if (mag[14:2] > 13'h1fde)
			m = 13'h1fff;
		else
			m = mag[14:2] + 13'h0021;
		e = 3'h0;
		for (int i = 1; i < 8; i++)
		begin
			if (m[i + (alaw ? 4 : 5)])
				e = 3'(i);
		end
		if (alaw)
			sh = (e == 3'h0) ? 4'h1 : {1'b0, e};
		else
			sh = {1'b0, e} + 4'h1;
		mt = 4'(m >> sh);
		compand = alaw ? ({~sg, e, mt} ^ 8'h55) : ~{sg, e, mt};
	endfunction
endpackage

// [shared/qcr_link_if.sv]
// bit timing carried from the clock block to the slot engines
interface qcr_link_if;
	logic                       tx_stb;
	logic                       rx_stb;
	logic                       frame;
	logic [qcr_pkg::BITW-1:0]   bit_idx;

	modport src (output tx_stb, output rx_stb, output frame, output bit_idx);
	modport snk (input tx_stb, input rx_stb, input frame, input bit_idx);
endinterface

// [rtl/qcr_clk.sv]
// clock block: link clock edges, frame sync, bit index, master tick
module qcr_clk (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// link pins, asynchronous
	input  wire logic                  hwy_clk_i,
	input  wire logic                  gci_clk_i,
	input  wire logic                  mclk_i,
	input  wire logic                  fs_i,
	// configuration
	input  wire logic                  gci_mode_i,
	input  wire logic                  tx_edge_i,
	input  wire logic                  mclk_sel_i,
	input  wire logic [qcr_pkg::CSW-1:0] clk_slot_i,
	// timing out
	qcr_link_if.src                    lk,
	output logic                       master_tick_o
);
	typedef struct packed {
		logic [2:0]               lclk;
		logic [2:0]               mclk;
		logic [1:0]               fs;
		logic                     fs_prev;
		logic [qcr_pkg::BITW-1:0] cnt;
		logic                     tick;
	} qcr_clk_st_t;

	qcr_clk_st_t             st_q;
	qcr_clk_st_t             st_d;
	logic                    rise;
	logic                    fall;
	logic                    fs_new;
	logic [qcr_pkg::BITW-1:0] frame_idx;

	assign rise      = st_q.lclk[1] & ~st_q.lclk[2];
	assign fall      = ~st_q.lclk[1] & st_q.lclk[2];
	assign frame_idx = {qcr_pkg::BITW{1'b0}} - {7'h00, clk_slot_i};
	assign lk.tx_stb = tx_edge_i ? fall : rise;
	assign lk.rx_stb = tx_edge_i ? rise : fall;
	// frame seen at each strobe of the first bit, up to and including the receive strobe
	assign fs_new    = st_q.fs[1] & ~st_q.fs_prev;
	assign lk.frame  = (lk.rx_stb | lk.tx_stb) & fs_new;
	assign lk.bit_idx = lk.frame ? frame_idx
		: (lk.tx_stb && tx_edge_i) ? st_q.cnt - 10'h001 : st_q.cnt;
	assign master_tick_o = st_q.tick;

	always_comb
	begin
		st_d = st_q;
		st_d.lclk = {st_q.lclk[1:0], gci_mode_i ? gci_clk_i : hwy_clk_i};
		st_d.mclk = {st_q.mclk[1:0], mclk_i};
		st_d.fs   = {st_q.fs[0], fs_i};
		if (lk.rx_stb)
		begin
			st_d.fs_prev = st_q.fs[1];
			st_d.cnt     = lk.bit_idx + 10'h001;
		end
		if (!gci_mode_i && mclk_sel_i)
			st_d.tick = st_q.mclk[1] & ~st_q.mclk[2];
		else
			st_d.tick = rise;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	property p_frame_count;
		@(posedge clk_i) disable iff (!rst_n_i)
		lk.frame && lk.rx_stb |=> (st_q.cnt == $past(frame_idx) + 10'h001);
	endproperty
	a_frame_count: assert property (p_frame_count)
		else $error("bit index not restarted at frame sync");

	property p_tx_edge;
		@(posedge clk_i) disable iff (!rst_n_i)
		lk.tx_stb |-> !lk.rx_stb && (st_q.lclk[1] != tx_edge_i)
			##1 !lk.tx_stb;
	endproperty
	a_tx_edge: assert property (p_tx_edge)
		else $error("transmit strobe on wrong clock edge");
endmodule

// [rtl/qcr_slot.sv]
// one voice channel slot engine: transmit and receive on the highway
module qcr_slot (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// bit timing
	qcr_link_if.snk          lk,
	// channel setup
	input  wire logic [6:0]  tx_slot_i,
	input  wire logic [6:0]  rx_slot_i,
	input  wire logic        lin_i,
	input  wire logic        sig_i,
	input  wire logic        alaw_i,
	// data
	input  wire logic [15:0] sample_i,
	input  wire logic [7:0]  sig_byte_i,
	input  wire logic        rx_bit_i,
	output logic             tx_bit_o,
	output logic             tx_act_o,
	output logic [15:0]      rx_word_o,
	output logic             rx_valid_o
);
	typedef struct packed {
		logic [15:0] txw;
		logic [15:0] rxsh;
		logic [15:0] rxw;
		logic        rxv;
	} qcr_slot_st_t;

	qcr_slot_st_t st_q;
	qcr_slot_st_t st_d;
	logic [6:0]   rel_t;
	logic [6:0]   rel_r;
	logic         rx_act;
	logic         rx_last;
	logic [3:0]   pos;
	logic [15:0]  rx_new;
	logic [15:0]  tx_new;
	logic [15:0]  tx_cur;

	assign rel_t    = lk.bit_idx[9:3] - tx_slot_i;
	assign rel_r    = lk.bit_idx[9:3] - rx_slot_i;
	assign tx_act_o = (rel_t == 7'h00) || ((lin_i || sig_i) && (rel_t == 7'h01));
	assign rx_act   = (rel_r == 7'h00) || (lin_i && (rel_r == 7'h01));
	assign rx_last  = (lk.bit_idx[2:0] == 3'h7) && (rel_r == {6'h00, lin_i});
	assign pos      = {rel_t[0], lk.bit_idx[2:0]};
	assign tx_new   = lin_i ? sample_i
		: {qcr_pkg::compand(sample_i, alaw_i), sig_byte_i};
	assign tx_cur   = lk.frame ? tx_new : st_q.txw;
	assign tx_bit_o = tx_cur[4'hf - pos];
	assign rx_new   = {st_q.rxsh[14:0], rx_bit_i};
	assign rx_word_o  = st_q.rxw;
	assign rx_valid_o = st_q.rxv;

	always_comb
	begin
		st_d = st_q;
		st_d.rxv = 1'b0;
		if (lk.frame)
			st_d.txw = tx_new;
		if (lk.rx_stb && rx_act)
		begin
			st_d.rxsh = rx_new;
			if (rx_last)
			begin
				st_d.rxw = lin_i ? rx_new : {8'h00, rx_new[7:0]};
				st_d.rxv = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	property p_comp_span;
		@(posedge clk_i) disable iff (!rst_n_i)
		!lin_i && !sig_i && (rel_t == 7'h01) |-> !tx_act_o;
	endproperty
	a_comp_span: assert property (p_comp_span)
		else $error("companded sample spans more than one slot");

	property p_rx_word;
		@(posedge clk_i) disable iff (!rst_n_i)
		rx_valid_o && !$past(lin_i) |-> (rx_word_o[15:8] == 8'h00) ##1 !rx_valid_o;
	endproperty
	a_rx_word: assert property (p_rx_word)
		else $error("companded receive word wider than a byte");
endmodule

// [rtl/qcr_top.sv]
// four-channel routing top: host registers, straps, highways, gci
//
// Chosen here: the address-and-strobe port and the register offsets.
module qcr_top (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// host register port
	input  wire logic [7:0]       addr_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic      [7:0]       rdata_o,
	// straps
	input  wire logic             gci_mode_i,
	input  wire logic             gci_pair_select_lo_i,
	input  wire logic             gci_pair_select_hi_i,
	// link pins
	input  wire logic             hwy_clk_i,
	input  wire logic             mclk_i,
	input  wire logic             gci_data_clock_i,
	input  wire logic             fs_i,
	input  wire logic [1:0]       dr_i,
	output logic      [1:0]       dx_o,
	output logic      [1:0]       dx_oe_o,
	// voice samples
	input  wire logic [3:0][15:0] tx_sample_i,
	output logic      [3:0][15:0] rx_sample_o,
	output logic      [3:0]       rx_valid_o,
	output logic                  master_tick_o
);
	typedef struct packed {
		logic [3:0]      chan_sel;
		logic [3:0][7:0] tx_slot;
		logic [3:0][7:0] rx_slot;
		logic [2:0]      clk_slot;
		logic            tx_edge;
		logic            mclk_sel;
		logic [3:0][2:0] mode;
		logic [3:0][7:0] sig;
		logic [1:0][7:0] mon_tx;
		logic [1:0][7:0] sc_tx;
		logic [1:0][7:0] mon_rx;
		logic [1:0][7:0] sc_rx;
		logic [7:0]      gsh;
		logic [7:0]      rdata;
		logic [2:0]      strap_s1;
		logic [2:0]      strap_s2;
		logic [2:0]      strap;
		logic [1:0]      strap_wait;
		logic            strap_done;
		logic [1:0]      dr_s1;
		logic [1:0]      dr_s2;
		logic [1:0]      dx;
		logic [1:0]      dx_oe;
	} qcr_st_t;

	localparam qcr_st_t ST_RST = '{
		mon_tx:  {2{qcr_pkg::RST_MON}},
		sc_tx:   {2{qcr_pkg::RST_SC}},
		default: '0
	};

	qcr_st_t          st_q;
	qcr_st_t          st_d;
	logic             gci;
	logic [2:0]       gbase;
	logic [3:0][6:0]  e_txs;
	logic [3:0][6:0]  e_rxs;
	logic [3:0]       e_lin;
	logic [3:0]       e_sig;
	logic [3:0]       e_hwy;
	logic [3:0]       tx_bit;
	logic [3:0]       tx_act;
	logic [3:0][15:0] rx_w;
	logic [1:0]       c_lo;
	logic             p_lo;
	logic [1:0]       m_hit;
	logic [1:0]       s_hit;
	logic [1:0]       hbit;
	logic [1:0]       hact;
	logic             per_chan;

	qcr_link_if lk ();

	assign gci   = st_q.strap[2];
	assign gbase = {st_q.strap[1:0], 1'b0};
	assign rdata_o = st_q.rdata;
	assign dx_o    = st_q.dx;
	assign dx_oe_o = st_q.dx_oe;
	assign rx_sample_o = rx_w;

	qcr_clk u_clk (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n_i),
		.hwy_clk_i     (hwy_clk_i),
		.gci_clk_i     (gci_data_clock_i),
		.mclk_i        (mclk_i),
		.fs_i          (fs_i),
		.gci_mode_i    (gci),
		.tx_edge_i     (st_q.tx_edge),
		.mclk_sel_i    (st_q.mclk_sel),
		.clk_slot_i    (st_q.clk_slot),
		.lk            (lk),
		.master_tick_o (master_tick_o)
	);

	// effective per-channel setup, gci overrides the host slots, linear, signalling and highway; alaw keeps the host value
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			if (gci)
			begin
				e_txs[c] = {2'b00, gbase + {2'b00, c[1]}, 1'b0, c[0]};
				e_rxs[c] = e_txs[c];
				e_lin[c] = 1'b0;
				e_sig[c] = 1'b0;
				e_hwy[c] = 1'b0;
			end
			else
			begin
				e_txs[c] = st_q.tx_slot[c][6:0];
				e_rxs[c] = st_q.rx_slot[c][6:0];
				e_lin[c] = st_q.mode[c][qcr_pkg::M_LIN];
				e_sig[c] = st_q.mode[c][qcr_pkg::M_SIG];
				e_hwy[c] = st_q.tx_slot[c][qcr_pkg::HWY_BIT];
			end
		end
	end

	for (genvar g = 0; g < 4; g++)
	begin : g_ch
		qcr_slot u_slot (
			.clk_i      (clk_i),
			.rst_n_i    (rst_n_i),
			.lk         (lk),
			.tx_slot_i  (e_txs[g]),
			.rx_slot_i  (e_rxs[g]),
			.lin_i      (e_lin[g]),
			.sig_i      (e_sig[g]),
			.alaw_i     (st_q.mode[g][qcr_pkg::M_ALAW]),
			.sample_i   (tx_sample_i[g]),
			.sig_byte_i (st_q.sig[g]),
			.rx_bit_i   (st_q.dr_s2[e_hwy[g]]),
			.tx_bit_o   (tx_bit[g]),
			.tx_act_o   (tx_act[g]),
			.rx_word_o  (rx_w[g]),
			.rx_valid_o (rx_valid_o[g])
		);
	end

	always_comb
	begin
		c_lo = 2'h0;
		for (int c = 3; c >= 0; c--)
		begin
			if (st_q.chan_sel[c])
				c_lo = 2'(c);
		end
		p_lo = ~(st_q.chan_sel[0] | st_q.chan_sel[1]);
		for (int j = 0; j < 2; j++)
		begin
			m_hit[j] = gci && (lk.bit_idx[9:3] ==
				{2'h0, gbase + {2'b00, j[0]}, qcr_pkg::GCI_MON_OFS});
			s_hit[j] = gci && (lk.bit_idx[9:3] ==
				{2'h0, gbase + {2'b00, j[0]}, qcr_pkg::GCI_SC_OFS});
		end
		per_chan = (addr_i == qcr_pkg::A_TXS_W) || (addr_i == qcr_pkg::A_RXS_W)
			|| (addr_i == qcr_pkg::A_MODE_W) || (addr_i == qcr_pkg::A_SIG_W);
	end

	// highway output merge, voice slots and gci control bytes
	always_comb
	begin
		hbit = 2'b00;
		hact = 2'b00;
		for (int c = 0; c < 4; c++)
		begin
			if (tx_act[c])
			begin
				hbit[e_hwy[c]] = hbit[e_hwy[c]] | tx_bit[c];
				hact[e_hwy[c]] = 1'b1;
			end
		end
		for (int j = 0; j < 2; j++)
		begin
			if (m_hit[j] || s_hit[j])
			begin
				hact[0] = 1'b1;
				hbit[0] = hbit[0] | (m_hit[j] ?
					st_q.mon_tx[j][3'h7 - lk.bit_idx[2:0]] :
					st_q.sc_tx[j][3'h7 - lk.bit_idx[2:0]]);
			end
		end
	end

	always_comb
	begin
		st_d = st_q;
		st_d.rdata    = 8'h00;
		st_d.strap_s1 = {gci_mode_i, gci_pair_select_hi_i, gci_pair_select_lo_i};
		st_d.strap_s2 = st_q.strap_s1;
		st_d.dr_s1    = dr_i;
		st_d.dr_s2    = st_q.dr_s1;
		if (!st_q.strap_done)
		begin
			if (st_q.strap_wait == qcr_pkg::STRAP_WAIT)
			begin
				st_d.strap      = st_q.strap_s2;
				st_d.strap_done = 1'b1;
			end
			else
				st_d.strap_wait = st_q.strap_wait + 2'h1;
		end
		if (lk.tx_stb)
		begin
			st_d.dx    = hbit;
			st_d.dx_oe = hact;
		end
		if (lk.rx_stb && (m_hit != 2'b00 || s_hit != 2'b00))
		begin
			st_d.gsh = {st_q.gsh[6:0], st_q.dr_s2[0]};
			if (lk.bit_idx[2:0] == 3'h7)
			begin
				for (int j = 0; j < 2; j++)
				begin
					if (m_hit[j])
						st_d.mon_rx[j] = st_d.gsh;
					if (s_hit[j])
						st_d.sc_rx[j] = st_d.gsh;
				end
			end
		end
		if (wr_i)
		begin
			for (int c = 0; c < 4; c++)
			begin
				if (st_q.chan_sel[c])
				begin
					if (addr_i == qcr_pkg::A_TXS_W)
						st_d.tx_slot[c] = wdata_i;
					if (addr_i == qcr_pkg::A_RXS_W)
						st_d.rx_slot[c] = wdata_i;
					if (addr_i == qcr_pkg::A_MODE_W)
						st_d.mode[c] = wdata_i[2:0];
					if (addr_i == qcr_pkg::A_SIG_W)
						st_d.sig[c] = wdata_i;
				end
			end
			for (int j = 0; j < 2; j++)
			begin
				if (st_q.chan_sel[2 * j] || st_q.chan_sel[2 * j + 1])
				begin
					if (addr_i == qcr_pkg::A_MON_W)
						st_d.mon_tx[j] = wdata_i;
					if (addr_i == qcr_pkg::A_SC_W)
						st_d.sc_tx[j] = wdata_i;
				end
			end
			if (addr_i == qcr_pkg::A_CSEL_W)
				st_d.chan_sel = wdata_i[3:0];
			if (addr_i == qcr_pkg::A_CLK_W)
			begin
				st_d.clk_slot = wdata_i[2:0];
				st_d.tx_edge  = wdata_i[qcr_pkg::EDGE_BIT];
			end
			if (addr_i == qcr_pkg::A_CFG_W)
				st_d.mclk_sel = wdata_i[qcr_pkg::MCLK_BIT];
			if (addr_i == qcr_pkg::A_RESET)
			begin
				st_d.chan_sel = ST_RST.chan_sel;
				st_d.tx_slot  = ST_RST.tx_slot;
				st_d.rx_slot  = ST_RST.rx_slot;
				st_d.clk_slot = ST_RST.clk_slot;
				st_d.tx_edge  = ST_RST.tx_edge;
				st_d.mclk_sel = ST_RST.mclk_sel;
				st_d.mode     = ST_RST.mode;
				st_d.sig      = ST_RST.sig;
				st_d.mon_tx   = ST_RST.mon_tx;
				st_d.sc_tx    = ST_RST.sc_tx;
			end
		end
		if (rd_i)
		begin
			case (addr_i)
				qcr_pkg::A_CSEL_R: st_d.rdata = {4'h0, st_q.chan_sel};
				qcr_pkg::A_TXS_R:  st_d.rdata = st_q.tx_slot[c_lo];
				qcr_pkg::A_RXS_R:  st_d.rdata = st_q.rx_slot[c_lo];
				qcr_pkg::A_MODE_R: st_d.rdata = {5'h00, st_q.mode[c_lo]};
				qcr_pkg::A_SIG_R:  st_d.rdata = st_q.sig[c_lo];
				qcr_pkg::A_CLK_R:  st_d.rdata = {4'h0, st_q.tx_edge, st_q.clk_slot};
				qcr_pkg::A_CFG_R:  st_d.rdata = {7'h00, st_q.mclk_sel};
				qcr_pkg::A_STAT_R: st_d.rdata = {4'h0, st_q.strap_done, st_q.strap};
				qcr_pkg::A_MON_R:  st_d.rdata = st_q.mon_tx[p_lo];
				qcr_pkg::A_SC_R:   st_d.rdata = st_q.sc_tx[p_lo];
				qcr_pkg::A_MONRX:  st_d.rdata = st_q.mon_rx[p_lo];
				qcr_pkg::A_SCRX:   st_d.rdata = st_q.sc_rx[p_lo];
				default:           st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_q <= ST_RST;
		else
			st_q <= st_d;
	end

	property p_one_chan;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && (addr_i == qcr_pkg::A_TXS_W) && (st_q.chan_sel == 4'h1)
		|=> (st_q.tx_slot[0] == $past(wdata_i)) && $stable(st_q.tx_slot[1])
			&& $stable(st_q.tx_slot[3]);
	endproperty
	a_one_chan: assert property (p_one_chan)
		else $error("single channel write reached wrong channel");

	property p_bcast;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && (addr_i == qcr_pkg::A_MODE_W) && (st_q.chan_sel == 4'hf)
		|=> (st_q.mode == {4{$past(wdata_i[2:0])}});
	endproperty
	a_bcast: assert property (p_bcast)
		else $error("broadcast write missed a channel");

	property p_sel_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && (addr_i == qcr_pkg::A_CSEL_R)
		|=> (rdata_o == {4'h0, $past(st_q.chan_sel)})
			##1 ((rdata_o == 8'h00) || $past(rd_i));
	endproperty
	a_sel_read: assert property (p_sel_read)
		else $error("channel select readback wrong");

	property p_no_sel;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && per_chan && (st_q.chan_sel == 4'h0)
		|=> $stable(st_q.mode) && $stable(st_q.tx_slot)
			&& $stable(st_q.rx_slot) && $stable(st_q.sig);
	endproperty
	a_no_sel: assert property (p_no_sel)
		else $error("write with no channel selected changed setup");

	property p_pair_map;
		@(posedge clk_i) disable iff (!rst_n_i)
		gci |-> (e_txs[0] == {2'b00, st_q.strap[1:0], 3'h0})
			&& (e_txs[3] == {2'b00, st_q.strap[1:0], 3'h5});
	endproperty
	a_pair_map: assert property (p_pair_map)
		else $error("gci channel pair not taken from straps");

	property p_gci_fmt;
		@(posedge clk_i) disable iff (!rst_n_i)
		gci |-> (e_lin == 4'h0) && (e_sig == 4'h0) && (e_hwy == 4'h0);
	endproperty
	a_gci_fmt: assert property (p_gci_fmt)
		else $error("linear or signalling active in gci mode");

	property p_soft_rst;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && (addr_i == qcr_pkg::A_RESET)
		|=> (st_q.chan_sel == 4'h0) && (st_q.mode == 12'h000);
	endproperty
	a_soft_rst: assert property (p_soft_rst)
		else $error("soft reset did not clear setup");

	property p_one_port;
		@(posedge clk_i) disable iff (!rst_n_i)
		gci && $past(gci) |-> !dx_oe_o[1];
	endproperty
	a_one_port: assert property (p_one_port)
		else $error("second highway driven in gci mode");
endmodule

// [bench/qcr_hwy_model.sv]
// highway switch model: link clock, frame sync and receive data
module qcr_hwy_model (
	// frame request
	input  wire logic       go_i,
	// highway pins
	output logic            hwy_clk_o,
	output logic            fs_o,
	output logic [1:0]      dr_o,
	output logic            busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NBITS = 80;
	initial
	begin
		hwy_clk_o = 1'b0;
		fs_o = 1'b0;
		dr_o = 2'h1;
		busy_o = 1'b0;
		forever
		begin
			@(posedge go_i);
			busy_o = 1'b1;
			for (int b = 0; b < NBITS; b++)
			begin
				// 160 ns bit clock, stands still between frames
				hwy_clk_o = 1'b1;
				fs_o = (b == 0);
				dr_o = (b == 0) ? 2'h2 : ~dr_o;
				#80;
				hwy_clk_o = 1'b0;
				#80;
			end
			fs_o = 1'b0;
			dr_o = ~dr_o;
			busy_o = 1'b0;
		end
	end
endmodule

// [bench/test_quad_codec_channel_routing.sv]
// self-checking bench of the channel routing top
module test_quad_codec_channel_routing;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk_i = 1'b0;
	logic             rst_n_i = 1'b0;
	logic [7:0]       addr_i = 8'h00;
	logic [7:0]       wdata_i = 8'h00;
	logic             wr_i = 1'b0;
	logic             rd_i = 1'b0;
	logic [7:0]       rdata_o;
	logic             lo_i = 1'b0;
	logic             hi_i = 1'b1;
	logic             hwy_clk;
	logic             fs;
	logic [1:0]       dr;
	logic [1:0]       dx_o;
	logic [1:0]       dx_oe_o;
	logic [3:0][15:0] tx_sample_i = '0;
	logic [3:0][15:0] rx_sample_o;
	logic [3:0]       rx_valid_o;
	logic             go = 1'b0;
	logic             busy;
	logic             pend = 1'b0;
	logic [7:0]       exp_q[$];
	int               err_total = 0;
	int               tests_run = 0;
	int               oe_cnt = 0;
	int               rxv_cnt = 0;
	logic [3:0]       sel;
	logic             gci_i = 1'b0;
	logic [15:0]      exp_rx = '0;
	logic [79:0]      line = '0;

	always #5 clk_i = ~clk_i;

	qcr_top qcr_top_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.gci_mode_i(gci_i), .gci_pair_select_lo_i(lo_i),
		.gci_pair_select_hi_i(hi_i), .hwy_clk_i(hwy_clk), .mclk_i(1'b0),
		.gci_data_clock_i(1'b0), .fs_i(fs), .dr_i(dr), .dx_o(dx_o),
		.dx_oe_o(dx_oe_o), .tx_sample_i(tx_sample_i),
		.rx_sample_o(rx_sample_o), .rx_valid_o(rx_valid_o),
		.master_tick_o());
	qcr_hwy_model qcr_hwy_model_i (
		.go_i(go), .hwy_clk_o(hwy_clk), .fs_o(fs), .dr_o(dr),
		.busy_o(busy));

	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic frame(input int e_oe, input logic lin);
		oe_cnt = 0;
		rxv_cnt = 0;
		exp_rx = lin ? 16'h5555 : 16'h0055;
		go <= 1'b1;
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		go <= 1'b0;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			@(posedge clk_i);
		chk("frame done", {15'h0000, busy}, 16'h0000);
		repeat (20) @(posedge clk_i);
		chk("oe bits", 16'(oe_cnt), 16'(e_oe));
		chk("rx valid", 16'(rxv_cnt), 16'h0004);
		if (lin)
			for (int c = 0; c < 4; c++)
				chk("tx word", line[79 - 16 * c -: 16], tx_sample_i[c]);
	endtask

	// read data stand in the cycle after the strobe
	always @(posedge clk_i) pend <= rd_i;
	always @(negedge clk_i)
		if (pend)
			chk("rdata", {8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
	always @(negedge hwy_clk)
	begin
		oe_cnt += int'(dx_oe_o[0] === 1'b1);
		line = {line[78:0], dx_o[0]};
	end
	always @(negedge clk_i)
	begin
		rxv_cnt += $countones(rx_valid_o);
		for (int c = 0; c < 4; c++)
			if (rx_valid_o[c] !== 1'b0)
				chk("rx word", rx_sample_o[c], exp_rx);
	end

	initial
	begin
		#500000;
		err_total++;
		stop_test();
	end

	initial
	begin
		void'($urandom(32'h4f0a4dd1));
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd(qcr_pkg::A_STAT_R, 8'h0a);
		rd(8'h5e, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			sel = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom());
			bus(1'b1, 1'b0, qcr_pkg::A_CSEL_W, {4'h0, sel});
			rd(qcr_pkg::A_CSEL_R, {4'h0, sel});
		end
		// two channels at once, then a write with nothing selected
		bus(1'b1, 1'b0, qcr_pkg::A_CSEL_W, 8'h05);
		bus(1'b1, 1'b0, qcr_pkg::A_MODE_W, 8'h03);
		bus(1'b1, 1'b0, qcr_pkg::A_CSEL_W, 8'h00);
		bus(1'b1, 1'b0, qcr_pkg::A_MODE_W, 8'h04);
		for (int c = 0; c < 4; c++)
		begin
			bus(1'b1, 1'b0, qcr_pkg::A_CSEL_W, 8'(1 << c));
			rd(qcr_pkg::A_MODE_R, (c % 2 == 0) ? 8'h03 : 8'h00);
			bus(1'b1, 1'b0, qcr_pkg::A_TXS_W, 8'(2 * c));
			rd(qcr_pkg::A_TXS_R, 8'(2 * c));
		end
		for (int c = 0; c < 4; c++)
			tx_sample_i[c] <= 16'($urandom());
		bus(1'b1, 1'b0, qcr_pkg::A_CSEL_W, 8'h0f);
		bus(1'b1, 1'b0, qcr_pkg::A_MODE_W, 8'h02);
		frame(64, 1'b1);
		bus(1'b1, 1'b0, qcr_pkg::A_MODE_W, 8'h01);
		frame(32, 1'b0);
		bus(1'b1, 1'b0, qcr_pkg::A_MODE_W, 8'h04);
		frame(64, 1'b0);
		rd(qcr_pkg::A_MODE_R, 8'h04);
		bus(1'b1, 1'b0, qcr_pkg::A_RESET, 8'h00);
		rd(qcr_pkg::A_CSEL_R, 8'h00);
		rd(qcr_pkg::A_MON_R, 8'hff);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		// second reset with the gci strap raised
		gci_i <= 1'b1;
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd(qcr_pkg::A_STAT_R, 8'h0e);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		stop_test();
	end
endmodule
